// [inc/guard_if.sv]
/*
 * internal carrier between the control top and its beam and
 * contactor helpers. assumes all ends share clk_i.
 */
`default_nettype none
interface guard_if;
    logic [1:0] code_sel;
    logic field_clear;
    logic outputs_on;
    logic both_open;
    logic fb_fault;

    modport ctrl (output code_sel, output outputs_on,
                  input field_clear, input both_open, input fb_fault);
    modport beam (input code_sel, output field_clear);
    modport feed (input outputs_on, output both_open, output fb_fault);
endinterface
`default_nettype wire

// [inc/guard_pkg.sv]
/*
 * constants, types and encodings shared by the light curtain receiver
 * control logic. assumes a single 10 MHz clock and synchronous inputs.
 */
`default_nettype none
package guard_pkg;
    // ========================================================
    // sizes
    localparam int BEAMS = 16;
    localparam int NAME_LEN = 22;
    localparam int NAME_IDX_W = 5;
    localparam int CHAR_W = 8;
    localparam int SYNC_BEAM = 0;
    localparam int MAX_SYSTEMS = 3;
    localparam int MAX_BEAMS_UNCODED = 480;
    localparam int MAX_BEAMS_CODED = 405;

    // ========================================================
    // beam coding settings
    typedef enum logic [1:0] {
        CODE_NONE = 2'h0,
        CODE_ONE = 2'h1,
        CODE_TWO = 2'h2
    } beam_code_t;

    // consecutive broken samples before the field counts as broken
    localparam logic [1:0] BREAK_SAMPLES_UNCODED = 2'h1;
    localparam logic [1:0] BREAK_SAMPLES_CODED = 2'h2;

    // ========================================================
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int SHOW_MS = 1000;
    localparam int FB_MS = 300;
    localparam int BLINK_MS = 250;
    localparam int SHOW_CYCLES = SHOW_MS * (CLK_HZ / 1000);
    localparam int FB_CYCLES = FB_MS * (CLK_HZ / 1000);
    localparam int BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);
    localparam int TIMER_W = 24;

    // ========================================================
    // status display codes
    typedef enum logic [3:0] {
        DISP_CODE_NONE = 4'h0,
        DISP_CODE_ONE = 4'h1,
        DISP_CODE_TWO = 4'h2,
        DISP_RUN = 4'h8,
        DISP_FB_ERROR = 4'he,
        DISP_LOCKOUT = 4'hf
    } disp_t;

    // ========================================================
    // control states, one-hot
    typedef enum logic [4:0] {
        ST_SHOW = 5'h01,
        ST_HOLD = 5'h02,
        ST_RUN = 5'h04,
        ST_FAULT = 5'h08,
        ST_LOCKOUT = 5'h10
    } state_t;
endpackage
`default_nettype wire

// [verification/contactor_model.sv]
/*
 * two external contactors driven by the safety outputs, each
 * reporting its contact through a feedback line that reads high
 * while open. assumes the coils follow the outputs on clk_i.
 */
`default_nettype none
module contactor_model (
    // clock
    input wire logic clk_i,
    // coil drive and fault injection
    input wire logic [1:0] coil_i,
    input wire logic weld_a_i,
    // feedback, high while open
    output logic fb_a_open_o,
    output logic fb_b_open_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // armature travel
    logic [1:0] stage_r = 2'h0;

    // two cycles of travel, far inside the settle window
    always_ff @(posedge clk_i) begin
        stage_r <= {stage_r[0], coil_i[0] & coil_i[1]};
    end

    // a welded contact stays closed whatever the coil does
    assign fb_a_open_o = !(stage_r[1] | weld_a_i);
    assign fb_b_open_o = !stage_r[1];
endmodule
`default_nettype wire

// [verification/curtain_ctrl_properties.sv]
/*
 * concurrent checks on the receiver control ports. assumes the
 * configuration inputs only change while reset is held.
 */
`default_nettype none
module curtain_ctrl_properties (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // configuration
    input wire logic restart_interlock_en_i,
    input wire logic contactor_feedback_check_i,
    input wire logic [1:0] beam_code_i,
    // beams and operator
    input wire logic [15:0] beam_rx_i,
    input wire logic interlock_btn_i,
    input wire logic [4:0] name_idx_i,
    // outputs
    input wire logic [7:0] name_char_o,
    input wire logic [1:0] safety_switch_output_o,
    input wire logic led_red_o,
    input wire logic led_green_o,
    input wire logic [3:0] disp_o
);
    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // the sync beam can never be blanked away
    a_break_drops_out: assert property (
        (safety_switch_output_o == 2'h3 && !beam_rx_i[0]) ##1 !beam_rx_i[0]
        |-> ##[1:3] safety_switch_output_o == 2'h0)
        else $error("outputs stayed on with a broken field");
    a_outputs_paired: assert property (
        safety_switch_output_o == 2'h0 || safety_switch_output_o == 2'h3)
        else $error("safety outputs split");
    a_on_shows_green: assert property (
        safety_switch_output_o == 2'h3 |-> led_green_o && !led_red_o)
        else $error("outputs on without green");
    a_start_needs_press: assert property (
        $rose(safety_switch_output_o[0]) && $past(restart_interlock_en_i)
        |-> $past(interlock_btn_i) || $past(interlock_btn_i, 2))
        else $error("outputs rose without a button press");
    a_power_up_show: assert property (
        $fell(rst_i) |=> (disp_o == {2'h0, beam_code_i}
        && safety_switch_output_o == 2'h0) [*8])
        else $error("coding not shown after power-up");
    a_fault_is_red: assert property (
        disp_o == 4'he |-> safety_switch_output_o == 2'h0 && led_red_o)
        else $error("feedback error with outputs on");
    a_lockout_holds: assert property (
        disp_o == 4'hf |=> disp_o == 4'hf && safety_switch_output_o == 2'h0)
        else $error("lock-out left without reset");
    a_unchecked_no_fault: assert property (
        !contactor_feedback_check_i |-> disp_o != 4'he && disp_o != 4'hf)
        else $error("feedback fault while checking is off");
    a_name_out_range: assert property (
        name_idx_i > 5'h15 |=> name_char_o == 8'h00)
        else $error("name slot beyond the last one read non-zero");
endmodule

bind curtain_ctrl curtain_ctrl_properties curtain_ctrl_properties_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_interlock_en_i(restart_interlock_en_i),
    .contactor_feedback_check_i(contactor_feedback_check_i),
    .beam_code_i(beam_code_i),
    .beam_rx_i(beam_rx_i),
    .interlock_btn_i(interlock_btn_i),
    .name_idx_i(name_idx_i),
    .name_char_o(name_char_o),
    .safety_switch_output_o(safety_switch_output_o),
    .led_red_o(led_red_o),
    .led_green_o(led_green_o),
    .disp_o(disp_o)
);
`default_nettype wire

// [verification/tb_curtain_ctrl.sv]
/*
 * self-checking bench for the receiver control top with contactor
 * model. assumes shortened show, settle and blink counts.
 */
`default_nettype none
module tb_curtain_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // signals
    logic clk_i, rst_i, restart_interlock_en_i, contactor_feedback_check_i;
    logic [1:0] beam_code_i, safety_switch_output_o;
    logic [15:0] beam_rx_i, beam_blank_i;
    logic [31:0] beam_tag_i;
    logic interlock_btn_i, fb_a_open_i, fb_b_open_i, weld, name_wr_i;
    logic led_red_o, led_green_o, led_yellow_o;
    logic [4:0] name_idx_i;
    logic [7:0] name_char_i, name_char_o;
    logic [3:0] disp_o;
    int failures = 0;
    int tests_run = 0;

    // ==========================================================
    // design and far side
    // a single 16-beam host stays inside every cascade limit
    curtain_ctrl #(.SHOW_CYCLES(20), .FB_CYCLES(10), .BLINK_CYCLES(4))
        curtain_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
        .restart_interlock_en_i(restart_interlock_en_i),
        .contactor_feedback_check_i(contactor_feedback_check_i),
        .beam_code_i(beam_code_i), .beam_rx_i(beam_rx_i),
        .beam_tag_i(beam_tag_i), .beam_blank_i(beam_blank_i),
        .interlock_btn_i(interlock_btn_i), .fb_a_open_i(fb_a_open_i),
        .fb_b_open_i(fb_b_open_i), .name_wr_i(name_wr_i),
        .name_idx_i(name_idx_i), .name_char_i(name_char_i),
        .name_char_o(name_char_o),
        .safety_switch_output_o(safety_switch_output_o),
        .led_red_o(led_red_o), .led_green_o(led_green_o),
        .led_yellow_o(led_yellow_o), .disp_o(disp_o));
    contactor_model contactor_model_inst (.clk_i(clk_i),
        .coil_i(safety_switch_output_o), .weld_a_i(weld),
        .fb_a_open_o(fb_a_open_i), .fb_b_open_o(fb_b_open_i));

    // ==========================================================
    // helpers
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // inputs move 1 ns after the rising edge, never on it
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic do_reset(input logic il, input logic fbc,
                            input logic [1:0] code);
        rst_i = 1'b1;
        restart_interlock_en_i = il;
        contactor_feedback_check_i = fbc;
        beam_code_i = code;
        beam_rx_i = 16'hffff;
        beam_tag_i = {16{code}};
        beam_blank_i = 16'h0000;
        interlock_btn_i = 1'b0;
        weld = 1'b0;
        cyc(16);
        rst_i = 1'b0;
        cyc(15);
        chk(8'(disp_o), 8'(code));
        chk(8'(safety_switch_output_o), 8'h00);
        cyc(30);
    endtask

    // held over several edges so the rising edge is surely seen;
    // reset role only, the machine's restart button comes after
    task automatic press();
        interlock_btn_i = 1'b1;
        cyc(3);
        interlock_btn_i = 1'b0;
        cyc(2);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_power_up();
        do_reset(1'b1, 1'b1, 2'h0);
        chk(8'(safety_switch_output_o), 8'h00);
        chk(8'(led_yellow_o), 8'h01);
        press();
        chk(8'(safety_switch_output_o), 8'h03);
        chk(8'({led_green_o, led_red_o}), 8'h02);
        chk(8'(disp_o), 8'h08);
        $display("power_up done");
    endtask

    task automatic t_break();
        beam_rx_i = 16'hffdf;
        cyc(4);
        chk(8'(safety_switch_output_o), 8'h00);
        press();
        chk(8'(safety_switch_output_o), 8'h00);
        beam_rx_i = 16'hffff;
        cyc(3);
        chk(8'(safety_switch_output_o), 8'h00);
        press();
        chk(8'(safety_switch_output_o), 8'h03);
        beam_blank_i = 16'h0021;
        beam_rx_i = 16'hffdf;
        cyc(5);
        chk(8'(safety_switch_output_o), 8'h03);
        beam_rx_i = 16'hfffe;
        cyc(5);
        chk(8'(safety_switch_output_o), 8'h00);
        $display("break done");
    endtask

    task automatic t_coded();
        do_reset(1'b1, 1'b1, 2'h1);
        beam_tag_i[7:6] = 2'h2;
        cyc(3); // coded break needs two samples to settle
        press();
        chk(8'(safety_switch_output_o), 8'h00);
        beam_tag_i[7:6] = 2'h1;
        cyc(2); // field clear is registered before a press counts
        press();
        chk(8'(safety_switch_output_o), 8'h03);
        beam_rx_i = 16'hfffb;
        cyc(1);
        beam_rx_i = 16'hffff;
        cyc(5);
        chk(8'(safety_switch_output_o), 8'h03);
        beam_rx_i = 16'hfffb;
        cyc(5);
        chk(8'(safety_switch_output_o), 8'h00);
        $display("coded done");
    endtask

    task automatic t_no_interlock();
        do_reset(1'b0, 1'b1, 2'h2);
        chk(8'(safety_switch_output_o), 8'h03);
        beam_rx_i = 16'hfdff;
        cyc(5);
        chk(8'(safety_switch_output_o), 8'h00);
        beam_rx_i = 16'hffff;
        cyc(8);
        chk(8'(safety_switch_output_o), 8'h03);
        $display("no_interlock done");
    endtask

    task automatic t_weld();
        int k;
        int tog;
        logic last;
        tog = 0;
        do_reset(1'b1, 1'b1, 2'h0);
        press();
        weld = 1'b1;
        beam_rx_i = 16'hffef;
        for (k = 0; k < 40 && disp_o !== 4'he; k++) cyc(1);
        chk(8'(disp_o), 8'h0e);
        chk(8'({safety_switch_output_o, led_red_o}), 8'h01);
        last = led_yellow_o;
        // a welded contact never reopens, so lock-out must follow
        for (k = 0; k < 60 && disp_o !== 4'hf; k++) begin
            cyc(1);
            if (led_yellow_o !== last) tog++;
            last = led_yellow_o;
        end
        chk(8'(tog != 0), 8'h01);
        chk(8'(disp_o), 8'h0f);
        beam_rx_i = 16'hffff;
        press();
        chk(8'(disp_o), 8'h0f);
        chk(8'(safety_switch_output_o), 8'h00);
        do_reset(1'b1, 1'b0, 2'h0);
        weld = 1'b1;
        cyc(15);
        press();
        chk(8'(safety_switch_output_o), 8'h03);
        chk(8'(disp_o), 8'h08);
        $display("weld done");
    endtask

    task automatic t_name();
        name_wr_i = 1'b1;
        name_idx_i = 5'h00;
        name_char_i = 8'h41;
        cyc(1);
        name_idx_i = 5'h15;
        name_char_i = 8'h5a;
        cyc(1);
        name_idx_i = 5'h16;
        name_char_i = 8'h77;
        cyc(1);
        name_wr_i = 1'b0;
        cyc(1);
        chk(name_char_o, 8'h00);
        name_idx_i = 5'h00;
        cyc(1);
        chk(name_char_o, 8'h41);
        name_idx_i = 5'h15;
        cyc(1);
        chk(name_char_o, 8'h5a);
        $display("name done");
    endtask

    // ==========================================================
    // run control
    task automatic test_done();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // about 440 cycles expected; the limit leaves wide slack
    initial begin
        #1000000;
        failures++;
        test_done();
    end

    initial begin
        name_wr_i = 1'b0;
        name_idx_i = 5'h00;
        name_char_i = 8'h00;
        t_power_up();
        t_break();
        t_coded();
        t_no_interlock();
        t_weld();
        t_name();
        test_done();
    end
endmodule
`default_nettype wire

// [verilog/beam_eval.sv]
/*
 * beam evaluation: accepts only beams with the selected coding and
 * debounces breaks longer when coding is on. assumes beam inputs are
 * synchronous samples of the optical receivers.
 */
`default_nettype none
module beam_eval (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // optical side
    input wire logic [guard_pkg::BEAMS-1:0] beam_rx_i,
    input wire logic [2*guard_pkg::BEAMS-1:0] beam_tag_i,
    input wire logic [guard_pkg::BEAMS-1:0] beam_blank_i,
    // carrier
    guard_if.beam bus
);
    logic [guard_pkg::BEAMS-1:0] ok;
    logic [1:0] cnt_r, cnt_nxt;
    logic clear_r, clear_nxt;
    logic [1:0] need;

    // ========================================================
    // per beam acceptance
    genvar i;
    generate
        for (i = 0; i < guard_pkg::BEAMS; i++) begin : g_beam
            logic tag_ok;
            assign tag_ok = (bus.code_sel == guard_pkg::CODE_NONE) ||
                (beam_tag_i[2*i +: 2] == bus.code_sel);
            if (i == guard_pkg::SYNC_BEAM) begin : g_sync
                // sync beam cannot be blanked: only light with the right coding syncs us
                assign ok[i] = beam_rx_i[i] && tag_ok;
            end else begin : g_norm
                assign ok[i] = beam_blank_i[i] || (beam_rx_i[i] && tag_ok);
            end
        end
    endgenerate

    // ========================================================
    // break debounce: coded beams need more samples to judge
    always_comb begin
        need = (bus.code_sel == guard_pkg::CODE_NONE) ?
            guard_pkg::BREAK_SAMPLES_UNCODED :
            guard_pkg::BREAK_SAMPLES_CODED;
        cnt_nxt = 2'h0;
        clear_nxt = clear_r;
        if (&ok) begin
            clear_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 2'h1;
            if (cnt_nxt >= need) begin
                clear_nxt = 1'b0;
                cnt_nxt = need;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 2'h0;
            clear_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            clear_r <= clear_nxt;
        end
    end

    assign bus.field_clear = clear_r;
endmodule
`default_nettype wire

// [verilog/contactor_chk.sv]
/*
 * contactor feedback watch: both contacts must follow the safety
 * outputs within a settle window. assumes feedback high = open.
 */
`default_nettype none
module contactor_chk #(
    parameter int FB_CYCLES = guard_pkg::FB_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // feedback contacts, high while open
    input wire logic fb_a_open_i,
    input wire logic fb_b_open_i,
    // carrier
    guard_if.feed bus
);
    logic [guard_pkg::TIMER_W-1:0] t_r, t_nxt;
    logic fault_r, fault_nxt;
    logic open_r, open_nxt;
    logic wrong;

    // ========================================================
    // a mismatch outlasting the settle window is a fault
    always_comb begin
        open_nxt = fb_a_open_i && fb_b_open_i;
        // on: both closed expected; off: both open expected
        wrong = bus.outputs_on ? (fb_a_open_i || fb_b_open_i) :
            !(fb_a_open_i && fb_b_open_i);
        t_nxt = '0;
        fault_nxt = 1'b0;
        if (wrong) begin
            t_nxt = t_r;
            if (t_r >= guard_pkg::TIMER_W'(FB_CYCLES - 1)) begin
                fault_nxt = 1'b1;
            end else begin
                t_nxt = t_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t_r <= '0;
            fault_r <= 1'b0;
            open_r <= 1'b0;
        end else begin
            t_r <= t_nxt;
            fault_r <= fault_nxt;
            open_r <= open_nxt;
        end
    end

    assign bus.both_open = open_r;
    assign bus.fb_fault = fault_r;
endmodule
`default_nettype wire

// [verilog/curtain_ctrl.sv]
/*
 * receiver control top: power-up coding display, restart interlock,
 * contactor feedback checking with lock-out, and the stored
 * application name. assumes synchronous inputs on a 10 MHz clock and
 * buttons that read high while pressed.
 */
`default_nettype none
module curtain_ctrl #(
    parameter int SHOW_CYCLES = guard_pkg::SHOW_CYCLES,
    parameter int FB_CYCLES = guard_pkg::FB_CYCLES,
    parameter int BLINK_CYCLES = guard_pkg::BLINK_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // configuration
    input wire logic restart_interlock_en_i,
    input wire logic contactor_feedback_check_i,
    input wire logic [1:0] beam_code_i,
    // optical receiver samples
    input wire logic [guard_pkg::BEAMS-1:0] beam_rx_i,
    input wire logic [2*guard_pkg::BEAMS-1:0] beam_tag_i,
    input wire logic [guard_pkg::BEAMS-1:0] beam_blank_i,
    // operator and contactors
    input wire logic interlock_btn_i,
    input wire logic fb_a_open_i,
    input wire logic fb_b_open_i,
    // application name store
    input wire logic name_wr_i,
    input wire logic [guard_pkg::NAME_IDX_W-1:0] name_idx_i,
    input wire logic [guard_pkg::CHAR_W-1:0] name_char_i,
    output logic [guard_pkg::CHAR_W-1:0] name_char_o,
    // safety outputs and indication
    output logic [1:0] safety_switch_output_o,
    output logic led_red_o,
    output logic led_green_o,
    output logic led_yellow_o,
    output logic [3:0] disp_o
);
    guard_if bus ();

    guard_pkg::state_t st_r, st_nxt;
    logic [guard_pkg::TIMER_W-1:0] tmr_r, tmr_nxt;
    logic [guard_pkg::TIMER_W-1:0] blink_cnt_r, blink_cnt_nxt;
    logic blink_r, blink_nxt;
    logic btn_r;
    logic btn_press;
    logic fb_ready;
    logic [1:0] code_r, code_nxt;
    logic [1:0] out_r, out_nxt;
    logic red_r, red_nxt;
    logic green_r, green_nxt;
    logic yellow_r, yellow_nxt;
    logic [3:0] disp_r, disp_nxt;
    logic [guard_pkg::CHAR_W-1:0] name_q_r, name_q_nxt;
    logic [guard_pkg::CHAR_W-1:0] name_mem_r [guard_pkg::NAME_LEN];

    // ========================================================
    // helpers
    beam_eval u_beam (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .beam_rx_i(beam_rx_i),
        .beam_tag_i(beam_tag_i),
        .beam_blank_i(beam_blank_i),
        .bus(bus.beam)
    );

    contactor_chk #(
        .FB_CYCLES(FB_CYCLES)
    ) u_fb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fb_a_open_i(fb_a_open_i),
        .fb_b_open_i(fb_b_open_i),
        .bus(bus.feed)
    );

    // coding is latched once per power-up so one cascade member
    // cannot drift away from the setting shared with the others
    assign bus.code_sel = code_r;
    assign bus.outputs_on = out_r[0];

    // ========================================================
    // button edge and contactor readiness
    always_comb begin
        btn_press = interlock_btn_i && !btn_r;
        // nothing is known of the machine-side interlock, so only
        // our own button, our own field and our own feedback gate a restart
        fb_ready = !contactor_feedback_check_i || bus.both_open;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            btn_r <= 1'b0;
        end else begin
            btn_r <= interlock_btn_i;
        end
    end

    // ========================================================
    // control state machine
    always_comb begin
        st_nxt = st_r;
        tmr_nxt = tmr_r;
        code_nxt = code_r;
        case (st_r)
            guard_pkg::ST_SHOW: begin
                code_nxt = beam_code_i;
                if (tmr_r >= guard_pkg::TIMER_W'(SHOW_CYCLES - 1)) begin
                    tmr_nxt = '0;
                    st_nxt = guard_pkg::ST_HOLD;
                end else begin
                    tmr_nxt = tmr_r + 1'b1;
                end
            end
            guard_pkg::ST_HOLD: begin
                tmr_nxt = '0;
                if (contactor_feedback_check_i && bus.fb_fault) begin
                    st_nxt = guard_pkg::ST_FAULT;
                end else if (bus.field_clear && fb_ready) begin
                    if (!restart_interlock_en_i) begin
                        st_nxt = guard_pkg::ST_RUN;
                    end else if (btn_press) begin
                        st_nxt = guard_pkg::ST_RUN;
                    end
                end
            end
            guard_pkg::ST_RUN: begin
                tmr_nxt = '0;
                if (!bus.field_clear) begin
                    st_nxt = guard_pkg::ST_HOLD;
                end else if (contactor_feedback_check_i && bus.fb_fault) begin
                    st_nxt = guard_pkg::ST_FAULT;
                end
            end
            guard_pkg::ST_FAULT: begin
                // a contact that never returns to open cannot be made
                // safe by us, so give up rather than retry forever
                if (bus.both_open) begin
                    tmr_nxt = '0;
                    st_nxt = guard_pkg::ST_HOLD;
                end else if (tmr_r >= guard_pkg::TIMER_W'(FB_CYCLES - 1)) begin
                    st_nxt = guard_pkg::ST_LOCKOUT;
                end else begin
                    tmr_nxt = tmr_r + 1'b1;
                end
            end
            guard_pkg::ST_LOCKOUT: begin
                st_nxt = guard_pkg::ST_LOCKOUT;
            end
            default: begin
                st_nxt = guard_pkg::ST_LOCKOUT;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= guard_pkg::ST_SHOW;
            tmr_r <= '0;
        end else begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
        end
    end

    // coding register: its next value only moves while on display
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_r <= guard_pkg::CODE_NONE;
        end else begin
            code_r <= code_nxt;
        end
    end

    // ========================================================
    // yellow flash timebase
    always_comb begin
        blink_cnt_nxt = blink_cnt_r + 1'b1;
        blink_nxt = blink_r;
        if (blink_cnt_r >= guard_pkg::TIMER_W'(BLINK_CYCLES - 1)) begin
            blink_cnt_nxt = '0;
            blink_nxt = !blink_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blink_cnt_r <= '0;
            blink_r <= 1'b0;
        end else begin
            blink_cnt_r <= blink_cnt_nxt;
            blink_r <= blink_nxt;
        end
    end

    // ========================================================
    // outputs and indication, all registered
    always_comb begin
        out_nxt = 2'b00;
        red_nxt = 1'b1;
        green_nxt = 1'b0;
        yellow_nxt = 1'b0;
        disp_nxt = guard_pkg::DISP_RUN;
        case (st_nxt)
            guard_pkg::ST_SHOW: begin
                disp_nxt = {2'b00, beam_code_i};
            end
            guard_pkg::ST_HOLD: begin
                // steady yellow: waiting for the interlock button
                yellow_nxt = restart_interlock_en_i && bus.field_clear;
            end
            guard_pkg::ST_RUN: begin
                out_nxt = 2'b11;
                red_nxt = 1'b0;
                green_nxt = 1'b1;
            end
            guard_pkg::ST_FAULT: begin
                disp_nxt = guard_pkg::DISP_FB_ERROR;
                yellow_nxt = restart_interlock_en_i && blink_r;
            end
            guard_pkg::ST_LOCKOUT: begin
                disp_nxt = guard_pkg::DISP_LOCKOUT;
            end
            default: begin
                disp_nxt = guard_pkg::DISP_LOCKOUT;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_r <= 2'b00;
            red_r <= 1'b1;
            green_r <= 1'b0;
            yellow_r <= 1'b0;
            disp_r <= guard_pkg::DISP_CODE_NONE;
        end else begin
            out_r <= out_nxt;
            red_r <= red_nxt;
            green_r <= green_nxt;
            yellow_r <= yellow_nxt;
            disp_r <= disp_nxt;
        end
    end

    // ========================================================
    // application name store; out-of-range indices are ignored
    always_comb begin
        name_q_nxt = '0;
        if (name_idx_i < guard_pkg::NAME_IDX_W'(guard_pkg::NAME_LEN)) begin
            name_q_nxt = name_mem_r[name_idx_i];
        end
    end

    genvar n;
    generate
        for (n = 0; n < guard_pkg::NAME_LEN; n++) begin : g_name
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    name_mem_r[n] <= '0;
                end else if (name_wr_i &&
                             name_idx_i == guard_pkg::NAME_IDX_W'(n)) begin
                    name_mem_r[n] <= name_char_i;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            name_q_r <= '0;
        end else begin
            name_q_r <= name_q_nxt;
        end
    end

    assign name_char_o = name_q_r;
    assign safety_switch_output_o = out_r;
    assign led_red_o = red_r;
    assign led_green_o = green_r;
    assign led_yellow_o = yellow_r;
    assign disp_o = disp_r;
endmodule
`default_nettype wire
